// ==== logic/adcr_pkg.sv ====
// package: register map, field positions and reset values of the analog-die control registers
// assumes an 8-bit register port reached from the die-to-die interface
package adcr_pkg;
    localparam logic [9:0] ADCR_BASE_BLOCKING = 10'h200;
    localparam logic [9:0] ADCR_BASE_NONBLOCKING = 10'h300;
    localparam logic [7:0] ADCR_OFS_SRC_HI = 8'h08;
    localparam logic [7:0] ADCR_OFS_SRC_LO = 8'h09;
    localparam logic [7:0] ADCR_OFS_MASK_HI = 8'h0c;
    localparam logic [7:0] ADCR_OFS_MASK_LO = 8'h0d;
    localparam logic [7:0] ADCR_OFS_LIFETIME_COUNTER_STATUS = 8'h3a;
    localparam logic [7:0] ADCR_OFS_LTC_HI = 8'h3c;
    localparam logic [7:0] ADCR_OFS_LTC_LO = 8'h3e;
    localparam logic [7:0] ADCR_OFS_CTL = 8'h40;
    localparam logic [7:0] ADCR_OFS_TX_ROUTE = 8'h54;
    localparam logic [7:0] ADCR_OFS_RX_ROUTE = 8'h55;
    localparam logic [7:0] ADCR_OFS_GAIN = 8'h62;
    localparam logic [7:0] ADCR_OFS_GCB = 8'h63;
    localparam logic [7:0] ADCR_OFS_COC = 8'hab;
    localparam logic [7:0] ADCR_RST_BYTE = 8'h00;
    localparam logic [15:0] ADCR_RST_WORD = 16'h0000;
    localparam logic [31:0] ADCR_RST_LTC = 32'h0000_0000;
    localparam int ADCR_BIT_ROUTE_PORT = 1;
    localparam int ADCR_BIT_ROUTE_SER = 0;
    localparam int ADCR_BIT_LTC_OVF = 7;
    localparam int ADCR_BIT_LTC_EN = 0;
    localparam int ADCR_BIT_AGC_EN = 1;
    localparam int ADCR_BIT_LTC_IRQ = 4;
    localparam int ADCR_GAIN_W = 3;
    localparam int ADCR_NGAIN = 8;
    typedef enum logic [1:0] {ADCR_RD_NONE, ADCR_RD_HI_FIRST, ADCR_RD_LO_FIRST} adcr_rd_t;
endpackage : adcr_pkg

// ==== logic/adcr_route_if.sv ====
// interface: bus transmit/receive routing between the register bank and the routing mux
// assumes one clock domain; purely combinational carriers
`timescale 1ns/1ns
interface adcr_route_if;
    logic [1:0] tx_sel;
    logic [1:0] rx_sel;
    logic ser_txd;
    logic port_txd;
    logic direct_txd;
    logic bus_rxd;
    logic bus_txd_next;
    logic [1:0] rx_next;
    modport bank(output tx_sel, output rx_sel, output ser_txd, output port_txd,
        output direct_txd, output bus_rxd, input bus_txd_next, input rx_next);
    modport mux(input tx_sel, input rx_sel, input ser_txd, input port_txd,
        input direct_txd, input bus_rxd, output bus_txd_next, output rx_next);
endinterface : adcr_route_if

// ==== logic/adcr_route.sv ====
// module: routing of the bus transmitter and receiver to serial block or port b
// assumes the bank registers the outputs
`timescale 1ns/1ns
module adcr_route (
    adcr_route_if.mux rt
);
    always_comb begin
        logic tx_src;
        tx_src = 1'b0;
        if (rt.tx_sel[adcr_pkg::ADCR_BIT_ROUTE_SER]) begin
            tx_src = rt.ser_txd;
        end else if (rt.tx_sel[adcr_pkg::ADCR_BIT_ROUTE_PORT]) begin
            tx_src = rt.port_txd;
        end
        rt.bus_txd_next = tx_src | rt.direct_txd;
        // idle level of a disconnected receiver path is recessive high
        rt.rx_next[1] = rt.rx_sel[adcr_pkg::ADCR_BIT_ROUTE_PORT] ? rt.bus_rxd : 1'b1;
        rt.rx_next[0] = rt.rx_sel[adcr_pkg::ADCR_BIT_ROUTE_SER] ? rt.bus_rxd : 1'b1;
    end
endmodule : adcr_route

// ==== logic/adcr_bank.sv ====
// module: analog-die control/status register bank with masks, gain, routing, lifetime counter
// assumes one byte-wide register port and a 16-bit port for the lifetime counter halves
`timescale 1ns/1ns
// Operation
// - high mask bits block their interrupt when set
// - low mask at 0x0D, bits 7..6 zero
// - blocking base 0x200, non-blocking base 0x300
// - gain write applies only without automatic gain
// - gain read returns gain in effect
// - gain code selects offset compensation buffer
// - threshold register holds up/down nibbles
// - transmit routing: bit1 port, bit0 serial
// - both set: serial block wins
// - selected source ORed with direct transmit
// - receive routing register at 0x55
// - overflow flag set, cleared by writing one
// - counter as two 16-bit halves only
// - reading a half freezes until other read
// - low source register reports six pending bits
module adcr_bank (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [9:0] i_addr,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_wide,
    input wire logic [15:0] i_wdata,
    input wire logic [7:0] i_irq_hi_src,
    input wire logic [5:0] i_irq_lo_src,
    input wire logic [2:0] i_agc_gain,
    input wire logic i_ser_txd,
    input wire logic i_port_txd,
    input wire logic i_direct_txd,
    input wire logic i_bus_rxd,
    input wire logic i_ltc_tick,
    output logic [15:0] o_rdata,
    output logic o_irq,
    output logic [2:0] o_gain_code,
    output logic [9:0] o_pga_gain,
    output logic [3:0] o_gain_up_thr,
    output logic [3:0] o_gain_down_thr,
    output logic o_auto_gain_enable,
    output logic o_bus_txd,
    output logic o_rx_to_port_b,
    output logic o_rx_to_serial_block
);
    function automatic logic [7:0] adcr_offset(input logic [9:0] a);
        // both windows map onto the same offsets
        if (a[9:8] == adcr_pkg::ADCR_BASE_BLOCKING[9:8] ||
            a[9:8] == adcr_pkg::ADCR_BASE_NONBLOCKING[9:8]) begin
            return a[7:0];
        end
        return 8'hff;
    endfunction : adcr_offset

    function automatic logic [9:0] adcr_gain_of(input logic [2:0] c);
        return 10'h004 << c;
    endfunction : adcr_gain_of

    adcr_route_if rt();
    adcr_route u_route (.rt(rt));

    logic [7:0] mask_hi_reg, mask_hi_next;
    logic [7:0] mask_lo_reg, mask_lo_next;
    logic [2:0] gain_reg, gain_next;
    logic [7:0] gcb_reg, gcb_next;
    logic [1:0] tx_reg, tx_next;
    logic [1:0] rx_reg, rx_next;
    logic [7:0] ctl_reg, ctl_next;
    logic ovf_reg, ovf_next;
    logic [31:0] ltc_reg, ltc_next;
    adcr_pkg::adcr_rd_t frz_reg, frz_next;
    logic [7:0] coc_reg [adcr_pkg::ADCR_NGAIN];
    logic [7:0] coc_wdata;
    logic coc_we;
    logic [15:0] rdata_next;
    logic irq_next;
    logic txd_next;
    logic ovf_set;
    logic [2:0] coc_idx;

    assign rt.tx_sel = tx_reg;
    assign rt.rx_sel = rx_reg;
    assign rt.ser_txd = i_ser_txd;
    assign rt.port_txd = i_port_txd;
    assign rt.direct_txd = i_direct_txd;
    assign rt.bus_rxd = i_bus_rxd;

    always_comb begin
        logic [7:0] ofs;
        logic [2:0] eff_gain;
        logic [5:0] lo_pend;
        ofs = adcr_offset(i_addr);
        mask_hi_next = mask_hi_reg;
        mask_lo_next = mask_lo_reg;
        gain_next = gain_reg;
        gcb_next = gcb_reg;
        tx_next = tx_reg;
        rx_next = rx_reg;
        ctl_next = ctl_reg;
        ovf_next = ovf_reg;
        ltc_next = ltc_reg;
        frz_next = frz_reg;
        ovf_set = 1'b0;
        coc_we = 1'b0;
        coc_wdata = i_wdata[7:0];
        rdata_next = adcr_pkg::ADCR_RST_WORD;
        lo_pend = i_irq_lo_src;
        lo_pend[adcr_pkg::ADCR_BIT_LTC_IRQ] = lo_pend[adcr_pkg::ADCR_BIT_LTC_IRQ] | ovf_reg;
        // in automatic mode the control unit's choice is the gain in effect
        eff_gain = ctl_reg[adcr_pkg::ADCR_BIT_AGC_EN] ? i_agc_gain : gain_reg;
        coc_idx = eff_gain;
        if (ctl_reg[adcr_pkg::ADCR_BIT_AGC_EN]) begin
            gain_next = i_agc_gain;
        end
        // counter runs while enabled and not frozen by a half read
        if (ctl_reg[adcr_pkg::ADCR_BIT_LTC_EN] && i_ltc_tick &&
            frz_reg == adcr_pkg::ADCR_RD_NONE) begin
            ltc_next = ltc_reg + 32'h0000_0001;
            if (ltc_reg == 32'hffff_ffff) begin
                ovf_next = 1'b1;
                ovf_set = 1'b1;
            end
        end
        if (i_wr) begin
            unique case (ofs)
                adcr_pkg::ADCR_OFS_MASK_HI: mask_hi_next = i_wdata[7:0];
                adcr_pkg::ADCR_OFS_MASK_LO: mask_lo_next = {2'b00, i_wdata[5:0]};
                adcr_pkg::ADCR_OFS_GAIN: begin
                    if (!ctl_reg[adcr_pkg::ADCR_BIT_AGC_EN]) begin
                        gain_next = i_wdata[2:0];
                    end
                end
                adcr_pkg::ADCR_OFS_GCB: gcb_next = i_wdata[7:0];
                adcr_pkg::ADCR_OFS_TX_ROUTE: tx_next = i_wdata[1:0];
                adcr_pkg::ADCR_OFS_RX_ROUTE: rx_next = i_wdata[1:0];
                adcr_pkg::ADCR_OFS_CTL: ctl_next = {6'h00, i_wdata[1:0]};
                adcr_pkg::ADCR_OFS_COC: coc_we = 1'b1;
                adcr_pkg::ADCR_OFS_LIFETIME_COUNTER_STATUS: begin
                    // a set in the same cycle wins over the clear
                    if (i_wdata[adcr_pkg::ADCR_BIT_LTC_OVF] && !ovf_set) begin
                        ovf_next = 1'b0;
                    end
                end
                adcr_pkg::ADCR_OFS_LTC_HI: begin
                    if (i_wide) begin
                        ltc_next[31:16] = i_wdata;
                    end
                end
                adcr_pkg::ADCR_OFS_LTC_LO: begin
                    if (i_wide) begin
                        ltc_next[15:0] = i_wdata;
                    end
                end
                default: ;
            endcase
        end
        if (i_rd) begin
            unique case (ofs)
                adcr_pkg::ADCR_OFS_SRC_HI: rdata_next = {8'h00, i_irq_hi_src};
                adcr_pkg::ADCR_OFS_SRC_LO: rdata_next = {10'h000, lo_pend};
                adcr_pkg::ADCR_OFS_MASK_HI: rdata_next = {8'h00, mask_hi_reg};
                adcr_pkg::ADCR_OFS_MASK_LO: rdata_next = {8'h00, mask_lo_reg};
                adcr_pkg::ADCR_OFS_GAIN: rdata_next = {13'h0, eff_gain};
                adcr_pkg::ADCR_OFS_GCB: rdata_next = {8'h00, gcb_reg};
                adcr_pkg::ADCR_OFS_TX_ROUTE: rdata_next = {14'h0, tx_reg};
                adcr_pkg::ADCR_OFS_RX_ROUTE: rdata_next = {14'h0, rx_reg};
                adcr_pkg::ADCR_OFS_CTL: rdata_next = {8'h00, ctl_reg};
                adcr_pkg::ADCR_OFS_COC: rdata_next = {8'h00, coc_reg[eff_gain]};
                adcr_pkg::ADCR_OFS_LIFETIME_COUNTER_STATUS: rdata_next = {8'h00, ovf_reg, 7'h00};
                adcr_pkg::ADCR_OFS_LTC_HI: begin
                    if (i_wide) begin
                        rdata_next = ltc_reg[31:16];
                        frz_next = (frz_reg == adcr_pkg::ADCR_RD_LO_FIRST) ?
                            adcr_pkg::ADCR_RD_NONE : adcr_pkg::ADCR_RD_HI_FIRST;
                    end
                end
                adcr_pkg::ADCR_OFS_LTC_LO: begin
                    if (i_wide) begin
                        rdata_next = ltc_reg[15:0];
                        frz_next = (frz_reg == adcr_pkg::ADCR_RD_HI_FIRST) ?
                            adcr_pkg::ADCR_RD_NONE : adcr_pkg::ADCR_RD_LO_FIRST;
                    end
                end
                default: rdata_next = adcr_pkg::ADCR_RST_WORD;
            endcase
        end
        // a set mask bit blocks the request, pending stays visible
        irq_next = |(i_irq_hi_src & ~mask_hi_reg) | |(lo_pend & ~mask_lo_reg[5:0]);
        txd_next = rt.bus_txd_next;
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mask_hi_reg <= adcr_pkg::ADCR_RST_BYTE;
            mask_lo_reg <= adcr_pkg::ADCR_RST_BYTE;
            gain_reg <= 3'h0;
            gcb_reg <= adcr_pkg::ADCR_RST_BYTE;
            tx_reg <= 2'h0;
            rx_reg <= 2'h0;
            ctl_reg <= adcr_pkg::ADCR_RST_BYTE;
            ovf_reg <= 1'b0;
            ltc_reg <= adcr_pkg::ADCR_RST_LTC;
            frz_reg <= adcr_pkg::ADCR_RD_NONE;
            o_rdata <= adcr_pkg::ADCR_RST_WORD;
            o_irq <= 1'b0;
            o_gain_code <= 3'h0;
            o_pga_gain <= 10'h004;
            o_gain_up_thr <= 4'h0;
            o_gain_down_thr <= 4'h0;
            o_auto_gain_enable <= 1'b0;
            o_bus_txd <= 1'b0;
            o_rx_to_port_b <= 1'b1;
            o_rx_to_serial_block <= 1'b1;
        end else begin
            mask_hi_reg <= mask_hi_next;
            mask_lo_reg <= mask_lo_next;
            gain_reg <= gain_next;
            gcb_reg <= gcb_next;
            tx_reg <= tx_next;
            rx_reg <= rx_next;
            ctl_reg <= ctl_next;
            ovf_reg <= ovf_next;
            ltc_reg <= ltc_next;
            frz_reg <= frz_next;
            o_rdata <= rdata_next;
            o_irq <= irq_next;
            o_gain_code <= gain_next;
            o_pga_gain <= adcr_gain_of(gain_next);
            o_gain_up_thr <= gcb_next[7:4];
            o_gain_down_thr <= gcb_next[3:0];
            o_auto_gain_enable <= ctl_next[adcr_pkg::ADCR_BIT_AGC_EN];
            o_bus_txd <= txd_next;
            o_rx_to_port_b <= rt.rx_next[1];
            o_rx_to_serial_block <= rt.rx_next[0];
        end
    end

    // offset compensation buffers, one per gain step
    for (genvar g = 0; g < adcr_pkg::ADCR_NGAIN; g++) begin : g_coc
        always_ff @(posedge i_mclk) begin
            if (i_sys_rst) begin
                coc_reg[g] <= adcr_pkg::ADCR_RST_BYTE;
            end else if (coc_we && coc_idx == 3'(g)) begin
                coc_reg[g] <= coc_wdata;
            end
        end
    end

    mask_blocks_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (mask_hi_reg == 8'hff && mask_lo_reg[5:0] == 6'h3f) |=> !o_irq)
        else $error("masked sources raised a request");
    low_mask_zero_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        mask_lo_reg[7:6] == 2'b00) else $error("low mask upper bits set");
    gain_hold_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (!ctl_reg[1] && !(i_wr && adcr_offset(i_addr) == adcr_pkg::ADCR_OFS_GAIN))
        |=> $stable(gain_reg)) else $error("gain changed without a write");
    gain_map_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $onehot(o_pga_gain) && o_pga_gain[{1'b0, o_gain_code} + 4'h2])
        else $error("gain code mapping wrong");
    thr_split_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $past(i_wr) && adcr_offset($past(i_addr)) == adcr_pkg::ADCR_OFS_GCB
        |-> ##1 o_gain_up_thr == $past(i_wdata[7:4], 2)) else $error("threshold wrong");
    tx_prio_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (tx_reg == 2'b11 && !i_direct_txd) |=> o_bus_txd == $past(i_ser_txd))
        else $error("serial block not given priority");
    ovf_set_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (ltc_reg == 32'hffff_ffff && ltc_next == 32'h0) |=> ovf_reg)
        else $error("overflow flag not set on wrap");
    freeze_cnt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (frz_reg != adcr_pkg::ADCR_RD_NONE && !i_wr) |=> $stable(ltc_reg))
        else $error("counter moved while a half read is open");
    set_wins_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        ovf_set |=> ovf_reg) else $error("overflow clear beat a set");
    ovf_clear_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_wr && adcr_offset(i_addr) == adcr_pkg::ADCR_OFS_LIFETIME_COUNTER_STATUS &&
        i_wdata[adcr_pkg::ADCR_BIT_LTC_OVF] && !ovf_set) |=> !ovf_reg)
        else $error("overflow flag not cleared by a one");
    auto_gain_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        ctl_reg[adcr_pkg::ADCR_BIT_AGC_EN] |=> o_gain_code == $past(i_agc_gain))
        else $error("automatic gain not in effect");
    gain_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_rd && !i_wr && adcr_offset(i_addr) == adcr_pkg::ADCR_OFS_GAIN)
        |=> o_rdata == {13'h0, o_gain_code}) else $error("gain read not in effect");
    tx_or_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_direct_txd |=> o_bus_txd) else $error("direct transmit not ORed in");
    rx_route_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        rx_reg[adcr_pkg::ADCR_BIT_ROUTE_PORT] |=> o_rx_to_port_b == $past(i_bus_rxd))
        else $error("receiver not routed to port b");
    narrow_read_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_rd && !i_wide) |=> frz_reg == $past(frz_reg))
        else $error("byte read moved the counter freeze");
    resume_cnt_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_rd && i_wide && adcr_offset(i_addr) == adcr_pkg::ADCR_OFS_LTC_LO &&
        frz_reg == adcr_pkg::ADCR_RD_HI_FIRST) |=> frz_reg == adcr_pkg::ADCR_RD_NONE)
        else $error("counter did not resume after second half");
    src_lo_zero_a: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (i_rd && adcr_offset(i_addr) == adcr_pkg::ADCR_OFS_SRC_LO)
        |=> o_rdata[15:6] == 10'h000)
        else $error("low source upper bits not zero");
endmodule : adcr_bank

// ==== verification/adcr_mcu_model.sv ====
// partner: mcu die side of the register port, one strobed access at a time
// assumes the bank answers a read on the edge after the strobe edge
`timescale 1ns/1ns
module adcr_mcu_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_rdata,
    output logic [9:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic o_wide,
    output logic [15:0] o_wdata
);
    initial begin
        o_addr = 10'h000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wide = 1'b0;
        o_wdata = 16'h0000;
    end
    task automatic access(input logic [9:0] addr, input logic wr, input logic [15:0] data,
        output logic [15:0] rdata);
        @(posedge i_mclk);
        o_addr <= addr;
        o_wr <= wr;
        o_rd <= !wr;
        o_wide <= addr[7:0] inside {8'h3c, 8'h3e};
        o_wdata <= data;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        o_addr <= ~addr;
        o_wdata <= ~data;
        @(posedge i_mclk);
        rdata = i_rdata;
    endtask : access
endmodule : adcr_mcu_model

// ==== verification/analog_die_control_registers_tb.sv ====
// testbench: random and corner accesses to the register bank through the mcu model
// assumes the bank and the mcu model compiled before it
`timescale 1ns/1ns
module analog_die_control_registers_tb;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [7:0] hi_src = 8'h00;
    logic [5:0] lo_src = 6'h00;
    logic [2:0] agc = 3'h0;
    logic ser = 1'b0;
    logic port = 1'b0;
    logic dir = 1'b0;
    logic rxd = 1'b0;
    logic tick = 1'b0;
    wire [9:0] addr;
    wire wr_s, rd_s, wide;
    wire [15:0] wdata, rdata;
    wire irq, txd, rx_pb, rx_sb, agc_en;
    wire [2:0] gcode;
    wire [9:0] pga;
    wire [3:0] up_thr, dn_thr;
    int error_cnt = 0;
    int tests_run = 0;
    always #5 i_mclk = ~i_mclk;
    adcr_mcu_model mcu_u (.i_mclk(i_mclk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr_s),
        .o_rd(rd_s), .o_wide(wide), .o_wdata(wdata));
    adcr_bank dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr(wr_s),
        .i_rd(rd_s), .i_wide(wide), .i_wdata(wdata), .i_irq_hi_src(hi_src),
        .i_irq_lo_src(lo_src), .i_agc_gain(agc), .i_ser_txd(ser), .i_port_txd(port),
        .i_direct_txd(dir), .i_bus_rxd(rxd), .i_ltc_tick(tick), .o_rdata(rdata), .o_irq(irq),
        .o_gain_code(gcode), .o_pga_gain(pga), .o_gain_up_thr(up_thr),
        .o_gain_down_thr(dn_thr), .o_auto_gain_enable(agc_en), .o_bus_txd(txd),
        .o_rx_to_port_b(rx_pb), .o_rx_to_serial_block(rx_sb));
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    function automatic logic [9:0] adr(input logic [7:0] ofs, input logic nb);
        return (nb ? adcr_pkg::ADCR_BASE_NONBLOCKING : adcr_pkg::ADCR_BASE_BLOCKING)
            | {2'h0, ofs};
    endfunction : adr
    task automatic wr(input logic [7:0] ofs, input logic [15:0] dat, input logic nb);
        logic [15:0] unused;
        mcu_u.access(adr(ofs, nb), 1'b1, dat, unused);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic nb, output logic [15:0] d);
        mcu_u.access(adr(ofs, nb), 1'b0, 16'h0000, d);
    endtask : rd
    function automatic logic exp_irq(input logic [7:0] hs, mh, input logic [5:0] ls, ml);
        return |(hs & ~mh) | |(ls & ~ml);
    endfunction : exp_irq
    function automatic logic exp_txd(input logic [1:0] sel, input logic s, p, d);
        return (sel[0] ? s : (sel[1] ? p : 1'b0)) | d;
    endfunction : exp_txd
    task automatic summarize();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        #300000;
        error_cnt++;
        summarize();
    end
    initial begin
        logic [15:0] d;
        logic [7:0] mh, ml, t;
        logic [7:0] rst_ofs [5] = '{8'h0d, 8'h3a, 8'h55, 8'h62, 8'h63};
        int i;
        i = $urandom(96);
        repeat (16) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        foreach (rst_ofs[k]) begin
            rd(rst_ofs[k], 1'b0, d);
            check("reset value", 16'h0000, d);
        end
        check("pga reset", 16'h0004, {6'h00, pga});
        rd(8'hf0, 1'b1, d);
        check("unmapped", 16'h0000, d);
        for (i = 0; i < 20; i++) begin
            mh = 8'($urandom);
            ml = 8'($urandom);
            wr(adcr_pkg::ADCR_OFS_MASK_HI, {8'h00, mh}, i[0]);
            wr(adcr_pkg::ADCR_OFS_MASK_LO, {8'h00, ml}, i[0]);
            @(posedge i_mclk);
            hi_src <= 8'($urandom);
            lo_src <= 6'($urandom);
            rd(adcr_pkg::ADCR_OFS_MASK_LO, !i[0], d);
            check("mask low", {10'h000, ml[5:0]}, d);
            rd(adcr_pkg::ADCR_OFS_SRC_LO, i[0], d);
            check("source low", {10'h000, lo_src}, d);
            check("irq", {15'h0, exp_irq(hi_src, mh, lo_src, ml[5:0])}, {15'h0, irq});
        end
        for (i = 0; i < 8; i++) begin
            wr(adcr_pkg::ADCR_OFS_GAIN, 16'(i), i[0]);
            rd(adcr_pkg::ADCR_OFS_GAIN, 1'b0, d);
            check("gain read", 16'(i), d);
            check("pga gain", 16'h0004 << i, {6'h00, pga});
            wr(adcr_pkg::ADCR_OFS_COC, {8'h00, 8'ha0 | 8'(i)}, i[1]);
        end
        for (i = 0; i < 8; i++) begin
            wr(adcr_pkg::ADCR_OFS_GAIN, 16'(i), 1'b0);
            rd(adcr_pkg::ADCR_OFS_COC, i[0], d);
            check("offset comp", {8'h00, 8'ha0 | 8'(i)}, d);
        end
        @(posedge i_mclk);
        agc <= 3'($urandom);
        wr(adcr_pkg::ADCR_OFS_CTL, 16'h0002, 1'b0);
        wr(adcr_pkg::ADCR_OFS_GAIN, {13'h0, ~agc}, 1'b0);
        rd(adcr_pkg::ADCR_OFS_GAIN, 1'b1, d);
        check("auto gain read", {13'h0, agc}, d);
        check("gain code", {13'h0, agc}, {13'h0, gcode});
        check("auto enable", 16'h0001, {15'h0, agc_en});
        rd(adcr_pkg::ADCR_OFS_COC, 1'b0, d);
        check("auto offset comp", {8'h00, 8'ha0 | {5'h00, agc}}, d);
        t = 8'($urandom);
        wr(adcr_pkg::ADCR_OFS_GCB, {8'h00, t}, 1'b0);
        check("thresholds", {8'h00, t}, {8'h00, up_thr, dn_thr});
        for (i = 0; i < 16; i++) begin
            wr(adcr_pkg::ADCR_OFS_TX_ROUTE, 16'(i[1:0]), 1'b0);
            wr(adcr_pkg::ADCR_OFS_RX_ROUTE, 16'(i[3:2]), 1'b1);
            @(posedge i_mclk);
            ser <= i[2];
            port <= i[3];
            dir <= 1'($urandom);
            rxd <= 1'($urandom);
            repeat (2) @(posedge i_mclk);
            #1;
            check("bus txd", {15'h0, exp_txd(i[1:0], ser, port, dir)}, {15'h0, txd});
            check("rx routes", {14'h0, i[3] ? rxd : 1'b1, i[2] ? rxd : 1'b1},
                {14'h0, rx_pb, rx_sb});
        end
        wr(adcr_pkg::ADCR_OFS_CTL, 16'h0000, 1'b0);
        wr(adcr_pkg::ADCR_OFS_LTC_HI, 16'hffff, 1'b0);
        wr(adcr_pkg::ADCR_OFS_LTC_LO, 16'hfffe, 1'b0);
        wr(adcr_pkg::ADCR_OFS_CTL, 16'h0001, 1'b0);
        @(posedge i_mclk);
        tick <= 1'b1;
        lo_src <= 6'h00;
        repeat (2) @(posedge i_mclk);
        tick <= 1'b0;
        rd(adcr_pkg::ADCR_OFS_LIFETIME_COUNTER_STATUS, 1'b0, d);
        check("overflow flag", 16'h0080, d);
        rd(adcr_pkg::ADCR_OFS_SRC_LO, 1'b0, d);
        check("overflow source", 16'h0010, d);
        wr(adcr_pkg::ADCR_OFS_LIFETIME_COUNTER_STATUS, 16'h0080, 1'b1);
        rd(adcr_pkg::ADCR_OFS_LIFETIME_COUNTER_STATUS, 1'b0, d);
        check("overflow clear", 16'h0000, d);
        rd(adcr_pkg::ADCR_OFS_LTC_HI, 1'b0, d);
        check("count high", 16'h0000, d);
        tick <= 1'b1;
        repeat (3) @(posedge i_mclk);
        tick <= 1'b0;
        rd(adcr_pkg::ADCR_OFS_LTC_LO, 1'b0, d);
        check("frozen low", 16'h0000, d);
        tick <= 1'b1;
        @(posedge i_mclk);
        tick <= 1'b0;
        rd(adcr_pkg::ADCR_OFS_LTC_LO, 1'b1, d);
        check("resumed low", 16'h0001, d);
        rd(adcr_pkg::ADCR_OFS_LTC_HI, 1'b1, d);
        check("resumed high", 16'h0000, d);
        summarize();
    end
endmodule : analog_die_control_registers_tb
